// File: design/bbtx_whiten_path.sv
// transmit payload buffers, packet type choice and data whitening
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "bbtx_consts.svh"
module bbtx_whiten_path #(
   parameter int SLV_W = 3
) (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst_b,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   output      logic [1:0]            s_axi_bresp,
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   output      logic [31:0]           s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic [6:1]            i_master_clk,
   input  wire logic [4:0]            i_hop_x,
   input  wire logic                  i_tx_slot,
   input  wire logic                  i_sco_slot,
   input  wire logic                  i_ack,
   input  wire logic                  i_nak,
   input  wire logic                  i_pkt_start,
   input  wire logic                  i_bit_valid,
   input  wire logic                  i_bit_data,
   output      bbtx_pkg::bbtx_desc_type o_desc,
   output      logic                  o_desc_valid,
   output      logic [31:0]           o_async_word,
   output      logic [31:0]           o_sync_word,
   output      logic                  o_wht_valid,
   output      logic                  o_wht_data
);
   localparam int NENT = 2 ** (SLV_W + 1);

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic       rst_n;
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic logic [SLV_W:0] ent(input logic [SLV_W-1:0] s, input logic h);
      ent = {s, h};
   endfunction

   function automatic logic [6:0] lfsr_step(input logic [6:0] w);
      lfsr_step = {w[5:4], w[3] ^ w[6], w[2:0], w[6]};
   endfunction

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   logic        aw_have_r;
   logic [7:0]  aw_addr_r;
   logic        w_have_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        wr_go;
   logic        wr_ctrl;
   logic        wr_async;
   logic        wr_sync;
   logic        wr_hit;
   logic        rd_go;
   logic        rd_hit;
   logic [31:0] rd_word;

   assign s_axi_awready = !aw_have_r && !bvalid_r;
   assign s_axi_wready  = !w_have_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign wr_go    = aw_have_r && w_have_r && !bvalid_r;
   assign wr_ctrl  = wr_go && (aw_addr_r == `BBTX_OFF_CTRL);
   assign wr_async = wr_go && (aw_addr_r == `BBTX_OFF_ASYNC) && (w_strb_r == 4'hF);
   assign wr_sync  = wr_go && (aw_addr_r == `BBTX_OFF_SYNC) && (w_strb_r == 4'hF);
   assign wr_hit   = (aw_addr_r == `BBTX_OFF_CTRL) || (aw_addr_r == `BBTX_OFF_ASYNC)
                   || (aw_addr_r == `BBTX_OFF_SYNC);
   assign rd_go    = s_axi_arvalid && !rvalid_r;
   assign rd_hit   = (s_axi_araddr == `BBTX_OFF_CTRL) || (s_axi_araddr == `BBTX_OFF_STATUS);

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_have_r  <= 1'b0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `BBTX_AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_hit ? `BBTX_AXI_OKAY : `BBTX_AXI_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= `BBTX_AXI_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_hit ? rd_word : 32'h0000_0000;
         rresp_r  <= rd_hit ? `BBTX_AXI_OKAY : `BBTX_AXI_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   logic [31:0]         ctrl_r;
   logic [SLV_W-1:0]    sel_slave;
   logic                flush;
   assign sel_slave = ctrl_r[`BBTX_CTRL_SLV_LSB +: SLV_W];
   assign flush     = wr_ctrl && w_data_r[`BBTX_CTRL_FLUSH];

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `BBTX_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= {16'h0000, w_data_r[15:0]};
      end
   end

   // ---------------------------------------------------------------
   // async buffers, one pair per slave
   // ---------------------------------------------------------------
   logic [31:0]          async_mem_r [NENT];
   logic [1:0]           async_lch_r [NENT];
   logic [NENT-1:0]      async_vld_r;
   logic [2**SLV_W-1:0]  async_sw_r;
   logic [SLV_W-1:0]     last_slave_r;
   logic                 ack_go;
   logic [SLV_W:0]       load_ent;
   logic [SLV_W:0]       read_ent;
   logic [SLV_W:0]       acked_ent;
   logic [1:0]           load_lch;
   // switch set: load half = sw, read half = ~sw, so the two never meet
   assign load_ent  = ent(sel_slave, async_sw_r[sel_slave]);
   assign read_ent  = ent(sel_slave, !async_sw_r[sel_slave]);
   assign acked_ent = ent(last_slave_r, !async_sw_r[last_slave_r]);
   assign ack_go    = i_ack && !i_nak;
   assign load_lch  = ctrl_r[`BBTX_CTRL_LM]   ? `BBTX_LCH_LM :
                      ctrl_r[`BBTX_CTRL_CONT] ? `BBTX_LCH_CONT :
                      `BBTX_LCH_START;

   always_ff @(posedge i_clk_sys) begin
      if (wr_async) begin
         async_mem_r[load_ent] <= w_data_r;
         async_lch_r[load_ent] <= load_lch;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         async_vld_r <= '0;
         async_sw_r  <= '0;
      end else begin
         // consumed register is emptied; the same ack moves the switch, so it is the next one loaded
         if (ack_go) begin
            async_vld_r[acked_ent] <= 1'b0;
         end
         if (wr_async) begin
            async_vld_r[load_ent] <= 1'b1;
         end
         // per-slave switch: ack for last served slave, flush for selected one
         for (int s = 0; s < 2 ** SLV_W; s++) begin
            if ((ack_go && last_slave_r == SLV_W'(s))
                || (flush && sel_slave == SLV_W'(s))) begin
               async_sw_r[s] <= !async_sw_r[s];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // sync buffer
   // ---------------------------------------------------------------
   logic [31:0] sync_mem_r [2];
   logic        sync_sw_r;
   always_ff @(posedge i_clk_sys) begin
      if (wr_sync) begin
         sync_mem_r[sync_sw_r] <= w_data_r;
      end
   end

   // ---------------------------------------------------------------
   // packet choice at each transmit slot
   // ---------------------------------------------------------------
   logic                   cur_vld;
   logic                   cur_lm;
   bbtx_pkg::bbtx_pkt_type pick;
   logic                   uses_async;
   assign cur_vld = async_vld_r[read_ent];
   assign cur_lm  = cur_vld && (async_lch_r[read_ent] == `BBTX_LCH_LM);
   assign pick =
      ctrl_r[`BBTX_CTRL_IDREQ]             ? bbtx_pkg::BBTX_PKT_ID :
      (i_sco_slot && cur_lm)               ? bbtx_pkg::BBTX_PKT_DM1 :
      (i_sco_slot && cur_vld)              ? bbtx_pkg::BBTX_PKT_DV :
      i_sco_slot                           ? bbtx_pkg::BBTX_PKT_HV :
      cur_lm                               ? bbtx_pkg::BBTX_PKT_DM1 :
      (cur_vld && ctrl_r[`BBTX_CTRL_GOOD]) ? bbtx_pkg::BBTX_PKT_DH1 :
      cur_vld                              ? bbtx_pkg::BBTX_PKT_DM1 :
      ctrl_r[`BBTX_CTRL_ACKPEND]           ? bbtx_pkg::BBTX_PKT_NULL :
      bbtx_pkg::BBTX_PKT_NONE;
   assign uses_async = (pick == bbtx_pkg::BBTX_PKT_DM1) || (pick == bbtx_pkg::BBTX_PKT_DH1)
                     || (pick == bbtx_pkg::BBTX_PKT_DV);

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_desc       <= '0;
         o_desc_valid <= 1'b0;
         o_async_word <= 32'h0000_0000;
         o_sync_word  <= 32'h0000_0000;
         last_slave_r <= '0;
         sync_sw_r    <= 1'b0;
      end else begin
         o_desc_valid <= i_tx_slot;
         if (i_tx_slot) begin
            o_desc.pkt     <= pick;
            o_desc.lch     <= uses_async ? async_lch_r[read_ent] : 2'h0;
            o_desc.slave   <= 3'(sel_slave);
            o_desc.has_hdr <= (pick != bbtx_pkg::BBTX_PKT_ID)
                              && (pick != bbtx_pkg::BBTX_PKT_NONE);
            // nak keeps the switch, so the same word is offered again
            o_async_word <= uses_async ? async_mem_r[read_ent] : 32'h0000_0000;
            last_slave_r <= sel_slave;
         end
         if (i_tx_slot && i_sco_slot) begin
            o_sync_word <= (pick == bbtx_pkg::BBTX_PKT_DM1) ? 32'h0000_0000
                           : sync_mem_r[!sync_sw_r];
            sync_sw_r   <= !sync_sw_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // data whitening
   // ---------------------------------------------------------------
   bbtx_pkg::bbtx_seed_type seed_mode;
   logic [6:0]              seed;
   logic [6:0]              wht_r;
   assign seed_mode = bbtx_pkg::bbtx_seed_type'(ctrl_r[`BBTX_CTRL_SEED_MSB:`BBTX_CTRL_SEED_LSB]);
   assign seed = (seed_mode == bbtx_pkg::BBTX_SEED_HOP79) ? {2'h3, i_hop_x} :
                 (seed_mode == bbtx_pkg::BBTX_SEED_HOP23) ? {2'h3, 1'b0, i_hop_x[3:0]} :
                 {1'b1, i_master_clk};

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wht_r       <= `BBTX_WHT_RST;
         o_wht_valid <= 1'b0;
         o_wht_data  <= 1'b0;
      end else begin
         o_wht_valid <= i_bit_valid && !i_pkt_start;
         if (i_pkt_start) begin
            wht_r <= seed;
         end else if (i_bit_valid) begin
            // one step per bit, header through CRC, never reloaded mid-packet
            wht_r      <= lfsr_step(wht_r);
            o_wht_data <= i_bit_data ^ wht_r[6];
         end
      end
   end

   // ---------------------------------------------------------------
   // status read word
   // ---------------------------------------------------------------
   assign rd_word = (s_axi_araddr == `BBTX_OFF_CTRL) ? ctrl_r :
      {8'h00, o_desc.pkt, o_desc.lch, sync_sw_r, cur_vld, 1'b0,
       8'(async_sw_r), 8'(async_vld_r[2*(2**SLV_W)-1 -: 8])};

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_seeded;
      i_pkt_start ##1 (i_bit_valid && !i_pkt_start);
   endsequence

   a_seed_clock: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      i_pkt_start && seed_mode == bbtx_pkg::BBTX_SEED_CLK
      |=> wht_r == {1'b1, $past(i_master_clk)})
      else $error("clock seed wrong");
   a_seed_hop79: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      i_pkt_start && seed_mode == bbtx_pkg::BBTX_SEED_HOP79
      |=> wht_r == {2'h3, $past(i_hop_x)})
      else $error("79-hop seed wrong");
   a_seed_hop23: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      i_pkt_start && seed_mode == bbtx_pkg::BBTX_SEED_HOP23
      |=> wht_r == {3'h6, $past(i_hop_x[3:0])})
      else $error("23-hop seed wrong");
   a_first_bit: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      s_seeded |=> o_wht_valid && o_wht_data == ($past(i_bit_data) ^ $past(wht_r[6])))
      else $error("first header bit not whitened by seed msb");
   a_lfsr_once: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      !i_pkt_start && !i_bit_valid |=> $stable(wht_r))
      else $error("lfsr moved without a bit");
   a_poly_step: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      !i_pkt_start && i_bit_valid |=> wht_r[0] == $past(wht_r[6])
      && wht_r[4] == ($past(wht_r[3]) ^ $past(wht_r[6])))
      else $error("feedback taps wrong");
   a_ack_switch: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      ack_go && !flush |=> async_sw_r[$past(last_slave_r)] != $past(async_sw_r[last_slave_r]))
      else $error("ack did not move switch");
   a_nak_hold: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      i_nak && !flush |=> $stable(async_sw_r))
      else $error("nak moved switch");
   a_lm_code: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      i_tx_slot && cur_lm && !ctrl_r[`BBTX_CTRL_IDREQ]
      |=> o_desc.pkt == bbtx_pkg::BBTX_PKT_DM1 && o_desc.lch == `BBTX_LCH_LM)
      else $error("link-manager payload not DM1 with code 11");
   a_null_idle: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      i_tx_slot && !i_sco_slot && !cur_vld && !ctrl_r[`BBTX_CTRL_IDREQ]
      |=> o_desc.pkt == (ctrl_r[`BBTX_CTRL_ACKPEND] ? bbtx_pkg::BBTX_PKT_NULL
                                                    : bbtx_pkg::BBTX_PKT_NONE))
      else $error("idle slot packet wrong");
   a_id_nohdr: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
      o_desc_valid |-> o_desc.has_hdr == (o_desc.pkt != bbtx_pkg::BBTX_PKT_ID
                                          && o_desc.pkt != bbtx_pkg::BBTX_PKT_NONE))
      else $error("header flag wrong");
endmodule

// File: design/bbtx_consts.svh
// register offsets, field positions and reset values of the transmit whitening path
`ifndef BBTX_CONSTS_SVH
`define BBTX_CONSTS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define BBTX_OFF_CTRL      8'h00
`define BBTX_OFF_ASYNC     8'h04
`define BBTX_OFF_SYNC      8'h08
`define BBTX_OFF_STATUS    8'h0C
// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define BBTX_CTRL_SLV_LSB  0
`define BBTX_CTRL_SLV_MSB  2
`define BBTX_CTRL_GOOD     3
`define BBTX_CTRL_ACKPEND  4
`define BBTX_CTRL_CONT     5
`define BBTX_CTRL_LM       6
`define BBTX_CTRL_SEED_LSB 8
`define BBTX_CTRL_SEED_MSB 9
`define BBTX_CTRL_IDREQ    10
`define BBTX_CTRL_FLUSH    16
`define BBTX_CTRL_RST      32'h0000_0000
// ---------------------------------------------------------------
// logical channel codes, whitening register reset value and bus response codes
// ---------------------------------------------------------------
`define BBTX_LCH_LM        2'h3
`define BBTX_LCH_START     2'h2
`define BBTX_LCH_CONT      2'h1
`define BBTX_WHT_RST       7'h7F
`define BBTX_AXI_OKAY      2'h0
`define BBTX_AXI_SLVERR    2'h2
`endif

// File: design/bbtx_pkg.sv
// types shared by the transmit whitening path
package bbtx_pkg;
   typedef enum logic [2:0] {
      BBTX_PKT_NONE = 3'h0,
      BBTX_PKT_NULL = 3'h1,
      BBTX_PKT_DM1  = 3'h2,
      BBTX_PKT_DH1  = 3'h3,
      BBTX_PKT_HV   = 3'h4,
      BBTX_PKT_DV   = 3'h5,
      BBTX_PKT_ID   = 3'h6
   } bbtx_pkt_type;

   typedef enum logic [1:0] {
      BBTX_SEED_CLK   = 2'h0,
      BBTX_SEED_HOP79 = 2'h1,
      BBTX_SEED_HOP23 = 2'h2
   } bbtx_seed_type;

   typedef struct packed {
      bbtx_pkt_type pkt;
      logic [1:0]   lch;
      logic [2:0]   slave;
      logic         has_hdr;
   } bbtx_desc_type;
endpackage

// File: sim/bbtx_peer.sv
// peer radio model: removes whitening and answers data packets
`timescale 1ns/100ps
module bbtx_peer (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic [6:0] i_seed,
   input  wire logic       i_start,
   input  wire logic       i_wht_valid,
   input  wire logic       i_wht_data,
   input  wire logic       i_desc_valid,
   input  wire logic [2:0] i_pkt,
   input  wire logic       i_nak_mode,
   input  wire logic [3:0] i_lat,
   output      logic       o_rx_bit,
   output      logic       o_ack,
   output      logic       o_nak
);
   logic [6:0] w_r;
   logic [3:0] cnt_r;
   // dm1, dh1 and dv carry payload and get an answer
   wire        is_data = i_desc_valid && (i_pkt inside {3'h2, 3'h3, 3'h5});
   assign o_rx_bit = i_wht_data ^ w_r[6];
   always_ff @(posedge i_clk) begin
      if (i_start) begin
         w_r <= i_seed;
      end else if (i_wht_valid) begin
         w_r <= {w_r[5:4], w_r[3] ^ w_r[6], w_r[2:0], w_r[6]};
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_r <= 4'h0;
         o_ack <= 1'b0;
         o_nak <= 1'b0;
      end else begin
         o_ack <= (cnt_r == 4'h1) && !i_nak_mode;
         o_nak <= (cnt_r == 4'h1) && i_nak_mode;
         cnt_r <= is_data ? i_lat : cnt_r - {3'h0, cnt_r != 4'h0};
      end
   end
endmodule

// File: sim/testbench.sv
// self-checking bench of the transmit whitening path
`timescale 1ns/100ps
`include "bbtx_consts.svh"
module testbench;
   localparam logic [7:0] a_ct = `BBTX_OFF_CTRL;
   localparam logic [7:0] a_as = `BBTX_OFF_ASYNC;
   localparam logic [7:0] a_sy = `BBTX_OFF_SYNC;
   localparam logic [1:0] ok = `BBTX_AXI_OKAY;
   localparam logic [1:0] er = `BBTX_AXI_SLVERR;
   logic                    clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
   logic                    arvalid, arready, rvalid, rready, tx_slot, sco, ack, nak;
   logic                    start, bval, bdat, wval, wdat, dval, rxb, nakm;
   logic [7:0]              awaddr, araddr;
   logic [31:0]             wdata, rdata, async_w, sync_w, got;
   logic [1:0]              bresp, rresp, gr;
   logic [6:1]              mclk;
   logic [4:0]              hop;
   logic [6:0]              pseed;
   logic [3:0]              lat;
   bbtx_pkg::bbtx_desc_type desc;
   int                      error_cnt, n_tests;
   bbtx_whiten_path #(.SLV_W(3)) u_dut (.i_clk_sys(clk), .i_rst_b(rst_b),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .i_master_clk(mclk), .i_hop_x(hop), .i_tx_slot(tx_slot), .i_sco_slot(sco),
      .i_ack(ack), .i_nak(nak), .i_pkt_start(start), .i_bit_valid(bval), .i_bit_data(bdat),
      .o_desc(desc), .o_desc_valid(dval), .o_async_word(async_w), .o_sync_word(sync_w),
      .o_wht_valid(wval), .o_wht_data(wdat));
   bbtx_peer u_peer (.i_clk(clk), .i_rst_b(rst_b), .i_seed(pseed), .i_start(start),
      .i_wht_valid(wval), .i_wht_data(wdat), .i_desc_valid(dval), .i_pkt(desc.pkt),
      .i_nak_mode(nakm), .i_lat(lat), .o_rx_bit(rxb), .o_ack(ack), .o_nak(nak));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // register bus master
   // ---------------------------------------------------------------
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic ta, tw, tb;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid & bready;
         gr = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            chk({30'h0, gr}, {30'h0, e});
            return;
         end
      end
      error_cnt++;
      report_and_stop();
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic ta, tr;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge clk);
         ta = arvalid & arready;
         tr = rvalid & rready;
         got = rdata;
         gr = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tr) begin
            rready <= 1'b0;
            chk({gr, got[29:0]}, {e, d[29:0]});
            return;
         end
      end
      error_cnt++;
      report_and_stop();
   endtask
   // ---------------------------------------------------------------
   // slot decision and whitening stream
   // ---------------------------------------------------------------
   task automatic slot(input logic s, input logic [2:0] pk);
      @(posedge clk);
      tx_slot <= 1'b1;
      sco <= s;
      @(posedge clk);
      tx_slot <= 1'b0;
      @(negedge clk);
      chk({dval, desc.pkt}, {1'b1, pk});
      for (int n = 0; n < 12 && !(ack || nak); n++) @(negedge clk);
      repeat (2) @(posedge clk);
   endtask
   task automatic whiten(input logic [1:0] m, input logic [6:0] sd);
      logic [6:0]  w;
      logic [15:0] d;
      d = 16'hA5C3;
      w = sd;
      axw(a_ct, {22'h0, m, 8'h00}, ok);
      pseed <= sd;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      for (int k = 0; k <= 16; k++) begin
         bval <= (k < 16);
         bdat <= d[k % 16];
         @(negedge clk);
         if (k > 0) begin
            chk({wval, wdat, rxb}, {1'b1, d[k-1] ^ w[6], d[k-1]});
            w = {w[5:4], w[3] ^ w[6], w[2:0], w[6]};
         end
         @(posedge clk);
      end
   endtask
   initial begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready, tx_slot, sco, start, bval, bdat} = '0;
      {awaddr, araddr, wdata, pseed} = '0;
      mclk = 6'h2D;
      hop = 5'h1A;
      nakm = 1'b1;
      lat = 4'h1;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      axr(a_ct, 32'h0, ok);
      axw(a_ct, 32'h1, ok);
      axr(a_ct, 32'h1, ok);
      axr(a_as, 32'h0, er);
      axw(`BBTX_OFF_STATUS, 32'h0, er);
      axw(8'h10, 32'h0, er);
      $display("register test done");
      axw(a_as, 32'h0A1A_0001, ok);
      axw(a_ct, 32'h0001_0001, ok);
      slot(1'b0, 3'h2);
      chk({desc.lch, desc.slave, desc.has_hdr, async_w[25:0]}, {6'h23, 26'h21A_0001});
      slot(1'b0, 3'h2);
      chk(async_w, 32'h0A1A_0001);
      nakm <= 1'b0;
      lat <= 4'h6;
      axw(a_ct, 32'h21, ok);
      axw(a_as, 32'h0B2B_0002, ok);
      slot(1'b0, 3'h2);
      chk(async_w, 32'h0A1A_0001);
      axw(a_ct, 32'h29, ok);
      slot(1'b0, 3'h3);
      chk({desc.lch, async_w[29:0]}, {2'h1, 30'h0B2B_0002});
      slot(1'b0, 3'h0);
      axw(a_ct, 32'h11, ok);
      slot(1'b0, 3'h1);
      axw(a_as, 32'h0C3C_0003, ok);
      slot(1'b0, 3'h1);
      axw(a_ct, 32'h0001_0011, ok);
      slot(1'b0, 3'h2);
      chk({desc.lch, async_w[29:0]}, {2'h2, 30'h0C3C_0003});
      $display("async buffer test done");
      axw(a_ct, 32'h41, ok);
      axw(a_as, 32'h0D4D_0004, ok);
      axw(a_ct, 32'h0001_0041, ok);
      slot(1'b1, 3'h2);
      chk({desc.lch, async_w[29:0]}, {2'h3, 30'h0D4D_0004});
      axw(a_ct, 32'h1, ok);
      axw(a_sy, 32'h5A5A_0100, ok);
      slot(1'b1, 3'h4);
      slot(1'b1, 3'h4);
      chk(sync_w, 32'h5A5A_0100);
      axw(a_as, 32'h0E5E_0005, ok);
      axw(a_ct, 32'h0001_0001, ok);
      slot(1'b1, 3'h5);
      chk({desc.lch, async_w[29:0]}, {2'h2, 30'h0E5E_0005});
      axw(a_ct, 32'h401, ok);
      slot(1'b0, 3'h6);
      chk({31'h0, desc.has_hdr}, 32'h0);
      axw(a_ct, 32'h2, ok);
      axw(a_as, 32'h0F6F_0006, ok);
      axw(a_ct, 32'h0001_0002, ok);
      axw(a_ct, 32'h11, ok);
      slot(1'b0, 3'h1);
      axw(a_ct, 32'h2, ok);
      slot(1'b0, 3'h2);
      chk({desc.slave, async_w[28:0]}, {3'h2, 29'h0F6F_0006});
      $display("channel mapping test done");
      whiten(2'h0, {1'b1, 6'h2D});
      whiten(2'h1, {2'b11, 5'h1A});
      whiten(2'h2, {3'b110, 4'hA});
      $display("whitening test done");
      report_and_stop();
   end
endmodule
